// file: dcsot_pkg.sv
/*
 * constants shared by the dual-channel sample output timing block:
 * code widths, input scaling, timing counts and latencies.
 * assumes a single 50 MHz system clock; the conversion clock is
 * derived from it by a divide-by-two.
 */
package dcsot_pkg;
    // system clock
    localparam int SYS_CLK_HZ = 50000000;
    localparam int SYS_PERIOD_NS = 20;
    // conversion clock is sys clock / 2, one half period per sys cycle
    localparam int CONV_DIV = 2;
    localparam int CONV_RATE_HZ = SYS_CLK_HZ / CONV_DIV;
    localparam int MAX_RATE_MSPS = 45;
    localparam int MAX_RATE_HZ = MAX_RATE_MSPS * 1000000;
    // latencies in tenths of a conversion cycle
    localparam int LAT_FIRST_TENTHS = 25;
    localparam int LAT_SECOND_TENTHS = 30;
    // latencies in sys cycles (half conversion periods)
    localparam int LAT_FIRST_SYS = (LAT_FIRST_TENTHS * CONV_DIV) / 10;
    localparam int LAT_SECOND_SYS = (LAT_SECOND_TENTHS * CONV_DIV) / 10;
    // due line taps: output regs load one edge after the visible tap
    localparam int DUE_LEN = LAT_FIRST_SYS;
    // code and input widths
    localparam int CODE_W = 10;
    localparam int WORD_W = 2 * CODE_W;
    localparam int SAMPLE_W = 13;
    localparam int FIFO_DEPTH = 16;
    // input scale: one input unit is vref / 2048
    localparam logic signed [SAMPLE_W-1:0] HALF_RANGE_LOW = 13'sh0400;
    localparam logic signed [SAMPLE_W-1:0] HALF_RANGE_HIGH = 13'sh0800;
    localparam int SHIFT_LOW = 1;
    localparam int SHIFT_HIGH = 2;
    localparam logic [CODE_W-1:0] CODE_NEG_FULL = 10'h000;
    localparam logic [CODE_W-1:0] CODE_POS_FULL = 10'h3FF;
    localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
endpackage

// file: dcsot_fifo.sv
/*
 * synchronous FIFO with valid/ready on both sides.
 * assumes one clock; read data is the head word, valid with o_out_valid.
 */
`timescale 1ns/1ps
`default_nettype none
module dcsot_fifo
    import dcsot_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
        logic full;
    } dcsot_fifo_state_type;

    dcsot_fifo_state_type st;
    dcsot_fifo_state_type next_st;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////
    // handshakes from registered flags only
    assign o_in_ready = !st.full;
    assign o_out_valid = (st.count != '0);
    assign o_out_data = st.mem[st.rptr];
    assign push = i_in_valid && !st.full;
    assign pop = i_out_ready && (st.count != '0);

    ////////////////////////////////////////////////////////////////
    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wptr] = i_in_data;
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
        // simultaneous push and pop leaves count unchanged
        next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.full = (next_st.count == (AW+1)'(DEPTH));
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// file: dcsot_top.sv
/*
 * dual-channel sample output timing: samples two channels together,
 * quantizes to ten bits and presents them in parallel or multiplexed
 * layout with fixed latency, through a 16-word buffer.
 * assumes sample inputs are synchronous to i_sys_clk and expressed in
 * units of vref/2048; the conversion clock is made here and driven out.
 */
// Notes on behaviour
// RULE1 - both channels sampled on conversion falling edge
// RULE2 - parallel layout: each channel own bus, rising
// RULE3 - multiplexed: first on rise, second on fall
// RULE4 - parallel latency 2.5 conversion cycles
// RULE5 - multiplexed latency 2.5 first, 3.0 second
// RULE6 - converts only while clocked and sleeps low
// RULE7 - out-of-range inputs saturate to full scale
// RULE8 - gain pin sets step factor 1 or 2
// RULE9 - one new result every conversion cycle
// RULE10 - ten-bit codes, rate at most 45 MSPS
// RULE11 - capture side latches on delayed phase indicator
// RULE12 - layout select high parallel, low multiplexed
// RULE13 - one shared clock drives both channels
// RULE14 - phase indicator high first, low second
`timescale 1ns/1ps
`default_nettype none
module dcsot_top
    import dcsot_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // analog sample stream, both channels together
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire logic signed [SAMPLE_W-1:0] i_first_sample,
    input wire logic signed [SAMPLE_W-1:0] i_second_sample,
    // control pins
    input wire logic i_gain_pin,
    input wire logic i_layout_select_pin,
    input wire logic i_deep_sleep_pin,
    input wire logic i_quick_sleep_pin,
    // conversion clock and output buses
    output logic o_conv_clk,
    output logic [CODE_W-1:0] o_first_channel_bus,
    output logic [CODE_W-1:0] o_second_channel_bus,
    output logic o_phase_ind,
    output logic o_running
);
    // rate check kept at elaboration: the divided clock stays in range
    localparam bit RATE_OK = (CONV_RATE_HZ <= MAX_RATE_HZ); // RULE10

    typedef struct packed {
        logic conv_clk;
        logic [DUE_LEN-1:0] due;
        logic [CODE_W-1:0] first_bus;
        logic [CODE_W-1:0] second_bus;
        logic [CODE_W-1:0] held_second;
        logic phase_ind;
        logic running;
        logic mux_pending;
    } dcsot_state_type;

    dcsot_state_type st;
    dcsot_state_type next_st;
    logic running_now;
    logic sample_edge;
    logic push;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic pop;
    logic [WORD_W-1:0] push_word;
    logic [WORD_W-1:0] head_word;

    ////////////////////////////////////////////////////////////////
    // quantizer: clamp to the range set by gain, then scale
    function automatic logic [CODE_W-1:0] dcsot_quantize(
        input logic signed [SAMPLE_W-1:0] x,
        input logic gain
    );
        logic signed [SAMPLE_W-1:0] half;
        logic [SAMPLE_W-1:0] shifted;
        half = gain ? HALF_RANGE_HIGH : HALF_RANGE_LOW; // RULE8
        shifted = '0;
        if (x < -half) begin
            dcsot_quantize = CODE_NEG_FULL; // RULE7
        end else if (x >= half) begin
            dcsot_quantize = CODE_POS_FULL; // RULE7
        end else begin
            // offset binary, step of 2 or 4 input units
            shifted = SAMPLE_W'(x + half);
            if (gain) begin
                dcsot_quantize = CODE_W'(shifted >> SHIFT_HIGH); // RULE10
            end else begin
                dcsot_quantize = CODE_W'(shifted >> SHIFT_LOW); // RULE10
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // conversion enable and sample capture
    assign running_now = !i_deep_sleep_pin && !i_quick_sleep_pin; // RULE6
    // conv clock high now, low after this edge: that edge samples
    assign sample_edge = running_now && st.conv_clk; // RULE1
    assign push = sample_edge && i_smp_valid && fifo_in_ready;
    // both channels quantized in the same cycle from one clock
    assign push_word = {dcsot_quantize(i_first_sample, i_gain_pin),
                        dcsot_quantize(i_second_sample, i_gain_pin)}; // RULE13
    // head leaves the buffer when its latency has run out
    assign pop = running_now && st.due[DUE_LEN-1] && fifo_out_valid; // RULE9

    ////////////////////////////////////////////////////////////////
    // buffer between sampling and output drivers; full stalls the source
    dcsot_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) dcsot_fifo_inst (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_in_valid(sample_edge && i_smp_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(push_word),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(head_word)
    );

    ////////////////////////////////////////////////////////////////
    // conversion clock, latency line and output stage
    always_comb begin
        next_st = st;
        next_st.running = running_now;
        if (running_now) begin
            // clock stops while asleep, so the pipeline freezes too
            next_st.conv_clk = !st.conv_clk; // RULE6
            next_st.due = {st.due[DUE_LEN-2:0], push}; // RULE4
            if (pop && i_layout_select_pin) begin
                // parallel: both buses on the rising conversion edge
                next_st.first_bus = head_word[WORD_W-1:CODE_W]; // RULE2
                next_st.second_bus = head_word[CODE_W-1:0]; // RULE2
                next_st.phase_ind = 1'b0;
                next_st.mux_pending = 1'b0;
            end else if (pop) begin
                // multiplexed: first word now, second half a cycle on
                next_st.first_bus = head_word[WORD_W-1:CODE_W]; // RULE3
                next_st.held_second = head_word[CODE_W-1:0];
                next_st.phase_ind = 1'b1; // RULE14
                next_st.mux_pending = 1'b1;
            end else if (st.mux_pending) begin
                // falling edge: second word on the first bus
                next_st.first_bus = st.held_second; // RULE5
                next_st.phase_ind = 1'b0; // RULE14
                next_st.mux_pending = 1'b0;
            end
            if (!i_layout_select_pin) begin
                // second bus idles at zero in multiplexed layout
                next_st.second_bus = CODE_RESET;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs, each straight from a state flip-flop
    assign o_smp_ready = fifo_in_ready;
    assign o_conv_clk = st.conv_clk;
    assign o_first_channel_bus = st.first_bus;
    assign o_second_channel_bus = st.second_bus;
    assign o_phase_ind = st.phase_ind;
    assign o_running = st.running;
endmodule
`default_nettype wire

// file: dcsot_asserts.sv
/*
 * port timing checker for dcsot_top.
 * assumes a bind from the bench top file and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module dcsot_asserts
    import dcsot_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // sample stream
    input wire logic i_smp_valid,
    input wire logic o_smp_ready,
    input wire logic signed [SAMPLE_W-1:0] i_first_sample,
    input wire logic signed [SAMPLE_W-1:0] i_second_sample,
    // control pins
    input wire logic i_gain_pin,
    input wire logic i_layout_select_pin,
    input wire logic i_deep_sleep_pin,
    input wire logic i_quick_sleep_pin,
    // outputs
    input wire logic o_conv_clk,
    input wire logic [CODE_W-1:0] o_first_channel_bus,
    input wire logic [CODE_W-1:0] o_second_channel_bus,
    input wire logic o_phase_ind,
    input wire logic o_running
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    AST_CONV_TOGGLE: assert property ((o_running && !i_deep_sleep_pin && !i_quick_sleep_pin) |=> $changed(o_conv_clk))
        else $error("conversion clock stalled while awake");
    AST_SLEEP_FREEZE: assert property ((i_deep_sleep_pin || i_quick_sleep_pin) |=> $stable(o_conv_clk) && $stable(o_first_channel_bus))
        else $error("activity while asleep");
    AST_RUNNING: assert property ($past(i_rst_b) |-> o_running == (!$past(i_deep_sleep_pin) && !$past(i_quick_sleep_pin)))
        else $error("running flag wrong");
    // layout taken from the edge that loaded the flops, not the one after
    AST_PHASE_MUX_ONLY: assert property ($rose(o_phase_ind) |-> !$past(i_layout_select_pin) && o_second_channel_bus == CODE_RESET)
        else $error("phase rise outside multiplexed layout");
    AST_PHASE_RISE_CLK: assert property ($rose(o_phase_ind) |-> $rose(o_conv_clk))
        else $error("first word not on clock rise");
    AST_PHASE_FALL_CLK: assert property ($fell(o_phase_ind) |-> $fell(o_conv_clk))
        else $error("second word not on clock fall");
    // the pins seen at the edge that must move the second word decide
    AST_PHASE_PAIR: assert property ($rose(o_phase_ind) && !i_deep_sleep_pin && !i_quick_sleep_pin |=> $fell(o_phase_ind))
        else $error("second word not half a cycle later");
    AST_PAR_UPDATE: assert property ($past(i_layout_select_pin) && ($changed(o_first_channel_bus) || $changed(o_second_channel_bus)) |-> $rose(o_conv_clk))
        else $error("parallel bus changed off the clock rise");
endmodule
`default_nettype wire

// file: dcsot_capture.sv
/*
 * capture model: latches multiplexed words on the delayed phase flag.
 * assumes the converter outputs change on rising sys clock edges.
 */
`timescale 1ns/1ps
`default_nettype none
module dcsot_capture
    import dcsot_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    // converter outputs
    input wire logic [CODE_W-1:0] i_bus,
    input wire logic i_phase_ind,
    // latched words
    output logic [CODE_W-1:0] o_first_word,
    output logic [CODE_W-1:0] o_second_word
);
    // phase seen one edge late keeps clear of the bus change
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_first_word <= CODE_RESET;
            o_second_word <= CODE_RESET;
        end else if (i_phase_ind) begin
            o_first_word <= i_bus;
        end else begin
            o_second_word <= i_bus;
        end
    end
endmodule
`default_nettype wire

// file: dcsot_top_tb.sv
/*
 * bench for dcsot_top: corner and random sample pairs, both layouts,
 * both gains, both sleep pins. assumes the capture model and checker.
 */
`timescale 1ns/1ps
`default_nettype none
module dcsot_top_tb;
    import dcsot_pkg::*;
    typedef struct {int t; logic par; logic [CODE_W-1:0] a; logic [CODE_W-1:0] b;} dcsot_exp_type;
    logic i_sys_clk, i_rst_b, i_smp_valid, i_gain_pin, i_layout_select_pin, i_deep_sleep_pin, i_quick_sleep_pin;
    logic signed [SAMPLE_W-1:0] i_first_sample, i_second_sample;
    logic o_smp_ready, o_conv_clk, o_phase_ind, o_running;
    logic [CODE_W-1:0] o_first_channel_bus, o_second_channel_bus, cap_first, cap_second;
    int fail_count, check_count, cyc;
    integer seed;
    // bench's own view of the conversion clock phase and the awake flag
    logic exp_clk, exp_run;
    int cx[10] = '{-4096, -2049, -2048, -1025, -1024, 1023, 1024, 2047, 2048, 4095};
    dcsot_exp_type q[$];

    dcsot_top dcsot_top_inst (.i_sys_clk, .i_rst_b, .i_smp_valid, .o_smp_ready, .i_first_sample,
        .i_second_sample, .i_gain_pin, .i_layout_select_pin, .i_deep_sleep_pin, .i_quick_sleep_pin,
        .o_conv_clk, .o_first_channel_bus, .o_second_channel_bus, .o_phase_ind, .o_running);
    dcsot_capture dcsot_capture_inst (.i_sys_clk, .i_rst_b, .i_bus(o_first_channel_bus),
        .i_phase_ind(o_phase_ind), .o_first_word(cap_first), .o_second_word(cap_second));

    ////////////////////////////////////////////////////////////////////////////////
    // ideal code; saturation at both ends of the range
    function automatic logic [CODE_W-1:0] code_of(input int x, input logic g);
        int h;
        h = g ? int'(HALF_RANGE_HIGH) : int'(HALF_RANGE_LOW);
        if (x < -h) return CODE_NEG_FULL;
        if (x >= h) return CODE_POS_FULL;
        return CODE_W'((x + h) >> (g ? SHIFT_HIGH : SHIFT_LOW));
    endfunction

    task automatic cmp(input string nm, input logic [CODE_W-1:0] e, input logic [CODE_W-1:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // results fall due 6, 7 and 8 falling edges after the take
    task automatic check();
        foreach (q[i]) begin
            if (cyc == q[i].t + 6) begin
                cmp("first bus", q[i].a, o_first_channel_bus);
                if (q[i].par) cmp("second bus", q[i].b, o_second_channel_bus);
                else cmp("phase high", 10'h001, {9'h000, o_phase_ind});
            end
            if (!q[i].par && cyc == q[i].t + 7) begin
                cmp("mux second", q[i].b, o_first_channel_bus);
                cmp("phase low", 10'h000, {9'h000, o_phase_ind});
            end
            if (!q[i].par && cyc == q[i].t + 8) begin
                cmp("cap first", q[i].a, cap_first);
                cmp("cap second", q[i].b, cap_second);
            end
        end
        while (q.size() > 0 && cyc >= q[0].t + (q[0].par ? 6 : 8))
            void'(q.pop_front());
    endtask

    // drive at the falling edge, predict the take from the bench's own phase, then check
    task automatic step(input logic v, input int a, input int b);
        cmp("conv clk", {9'h000, exp_clk}, {9'h000, o_conv_clk});
        cmp("running", {9'h000, exp_run}, {9'h000, o_running});
        // at most three words in flight, so the 16-word buffer never fills
        cmp("ready", 10'h001, {9'h000, o_smp_ready});
        i_smp_valid = v;
        i_first_sample = SAMPLE_W'(a);
        i_second_sample = SAMPLE_W'(b);
        if (v && exp_clk && !i_deep_sleep_pin && !i_quick_sleep_pin)
            q.push_back('{cyc, i_layout_select_pin, code_of(i_first_sample, i_gain_pin), code_of(i_second_sample, i_gain_pin)});
        exp_run = !i_deep_sleep_pin && !i_quick_sleep_pin;
        if (exp_run)
            exp_clk = !exp_clk;
        @(negedge i_sys_clk);
        cyc++;
        check();
    endtask

    // 50 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end

    // whole run is near 700 cycles; generous margin
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end

    // corners first in each mode, then random pairs
    initial begin
        seed = 5417;
        exp_clk = 1'b0;
        exp_run = 1'b0;
        {i_rst_b, i_smp_valid, i_gain_pin, i_deep_sleep_pin, i_quick_sleep_pin} = 5'h00;
        i_layout_select_pin = 1'b1;
        i_first_sample = '0;
        i_second_sample = '0;
        repeat (8) @(negedge i_sys_clk);
        i_rst_b = 1'b1;
        for (int m = 0; m < 4; m++) begin
            i_layout_select_pin = m[0];
            i_gain_pin = m[1];
            for (int k = 0; k < 150; k++) begin
                // each corner stands two cycles so one of them meets a sampling edge
                if (k < 20)
                    step(1'b1, cx[k / 2], cx[9 - k / 2]);
                else
                    step(($random(seed) & 3) != 0, $random(seed), $random(seed));
            end
            repeat (10) step(1'b0, 0, 0);
        end
        i_deep_sleep_pin = 1'b1;
        repeat (6) step(1'b1, 5, 5);
        i_deep_sleep_pin = 1'b0;
        i_quick_sleep_pin = 1'b1;
        repeat (6) step(1'b1, 5, 5);
        i_quick_sleep_pin = 1'b0;
        repeat (20) step(1'b1, $random(seed), $random(seed));
        repeat (12) step(1'b0, 0, 0);
        stop_test();
    end
endmodule

bind dcsot_top dcsot_asserts dcsot_asserts_inst (.i_sys_clk, .i_rst_b, .i_smp_valid, .o_smp_ready,
    .i_first_sample, .i_second_sample, .i_gain_pin, .i_layout_select_pin, .i_deep_sleep_pin,
    .i_quick_sleep_pin, .o_conv_clk, .o_first_channel_bus, .o_second_channel_bus, .o_phase_ind, .o_running);
`default_nettype wire
